//--- hw/scrc_regs.svh
/*
 Timing constants and fixed figures of the secondary cycle request control.
 Assumes a 250 MHz system clock; times are given in ns and converted here.
*/
`ifndef SCRC_REGS_SVH
`define SCRC_REGS_SVH
`define SCRC_CLK_NS            4
`define SCRC_MIN_OFF_NS        2000
`define SCRC_MIN_PERIOD_NS     5000
`define SCRC_START_PERIOD_NS   10000
`define SCRC_SOFT_START_NS     10000000
`define SCRC_ON_TIMEOUT_NS     30000
`define SCRC_DEGLITCH_NS       8000
`define SCRC_UV_FILTER_NS      64000000
`define SCRC_SKIP_TIMEOUT_NS   100000000
`define SCRC_VALLEY_NS         20000
`define SCRC_BLANK_NS          800
`define SCRC_NO_ANSWER_MAX     4'h8
`define SCRC_UNASKED_MAX       4'h4
`define SCRC_SYNC_STAGES       2'h2
`define SCRC_CYC(ns)           ((ns) / `SCRC_CLK_NS)
`endif

//--- hw/scrc_pkg.sv
/*
 Types shared by the secondary cycle request control.
 Assumes scrc_regs.svh supplies the timing figures.
*/
`default_nettype none
package scrc_pkg;
   typedef enum logic [2:0] {
      SCRC_IDLE      = 3'b000,
      SCRC_HANDSHAKE = 3'b001,
      SCRC_SOFTSTART = 3'b011,
      SCRC_RUN       = 3'b010,
      SCRC_FAULT     = 3'b110
   } scrc_state_t;

   // Comparator outputs from the analog front end
   typedef struct packed {
      logic fwd_fall;
      logic ring_large;
      logic dcm_seen;
      logic fb_in_reg;
      logic fb_short;
      logic fb_uv;
      logic fb_ov2;
      logic fb_ov10;
      logic fb_ov20;
      logic supply_oc;
      logic cs_over;
      logic cs_surge;
      logic gate_small;
      logic gate_grounded;
   } scrc_cmp_t;

   typedef struct packed {
      logic bleed_weak;
      logic bleed_strong;
      logic fault_cmd;
      logic fault_latch;
      logic cc_active;
   } scrc_prot_t;
endpackage
`default_nettype wire

//--- hw/scrc_timer.sv
/*
 Generic retriggerable down-counter used for the soft-start, undervoltage, skip, deglitch, on-timeout and valley timers.
 Assumes load and run come from logic on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module scrc_timer #(
   parameter int W = 25
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   input  wire logic         run,
   output logic              done
);
   logic [W-1:0] cnt;
   logic         armed;

   assign done = armed && (cnt == '0);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt   <= '0;
         armed <= 1'b0;
      end else if (load) begin
         cnt   <= count;
         armed <= 1'b1;
      end else if (run && cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- hw/scrc_top.sv
/*
 Secondary-side cycle request control: request pacing, soft-start ramp,
 protections and rectifier gate drive. Assumes all comparator inputs are
 asynchronous levels from analog blocks and cycle_request feeds the link.
*/
// How it works
// - No new request before minimum off-time after primary conduction ends.
// - Start-up requests paced at the start-up limit, 100 kHz, reduced current.
// - Feedback-short check masked until 10 ms soft-start timer expires.
// - After handshake, request rate ramps linearly up over 10 ms.
// - Start-up overload goes to constant current; undervoltage at end restarts or latches per option.
// - Regulation during soft-start aborts ramp, only after resonant programming.
// - Requests blocked until forward falling edge, with 30 us timeout.
// - Feedback 2% high enables weak output bleed.
// - Feedback 10% high enables strong bleed; control kept meanwhile.
// - Feedback 20% high sends fault command, latch or restart per option.
// - Short at start-up: finish handshake and ramp, then stop requests.
// - Deglitched feedback short in run stops requests, releases control.
// - Undervoltage longer than filter time releases control.
// - Supply overcurrent in control commands restart or latch-off.
// - Current regulation compares sense voltage to 35 mV reference.
// - Rectifier gate only after own request and forward falling edge.
// - Sense surge above three times threshold disables rectifier gate.
// - Rectifier gate held low whenever secondary is not in control.
// - Gate load under 200 pF means open gate; stop requests.
// - Gate grounded at start-up disables drive and open-gate check.
// - Valley gating for 20 us after discontinuous mode, and while the ring is large.
// - Forward edge detection blanked for 800 ns.
// - Eight unanswered or four unasked cycles restart the handshake.
// - In continuous conduction, gate turns off at the request pulse.
`timescale 1ns/1ns
`default_nettype none
`include "scrc_regs.svh"
module scrc_top #(
   parameter int SOFT_START_CYC = `SCRC_CYC(`SCRC_SOFT_START_NS),
   parameter int UV_FILTER_CYC  = `SCRC_CYC(`SCRC_UV_FILTER_NS),
   parameter int SKIP_CYC       = `SCRC_CYC(`SCRC_SKIP_TIMEOUT_NS),
   parameter int DEGLITCH_CYC   = `SCRC_CYC(`SCRC_DEGLITCH_NS),
   parameter int ON_TIMEOUT_CYC = `SCRC_CYC(`SCRC_ON_TIMEOUT_NS),
   parameter int VALLEY_CYC     = `SCRC_CYC(`SCRC_VALLEY_NS)
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire scrc_pkg::scrc_cmp_t cmp_async,
   input  wire logic              qr_programmed,
   input  wire logic              fault_latch_option,
   output logic                   cycle_request,
   output logic                   sync_rectifier_gate,
   output logic                   gate_pulldown,
   output scrc_pkg::scrc_prot_t   prot,
   output logic                   in_control,
   output logic                   handshake_restart
);
   localparam int TW = 26;
   localparam logic [TW-1:0] MIN_OFF   = TW'(`SCRC_CYC(`SCRC_MIN_OFF_NS));
   localparam logic [TW-1:0] MIN_PER   = TW'(`SCRC_CYC(`SCRC_MIN_PERIOD_NS));
   localparam logic [TW-1:0] START_PER = TW'(`SCRC_CYC(`SCRC_START_PERIOD_NS));
   localparam logic [TW-1:0] BLANK     = TW'(`SCRC_CYC(`SCRC_BLANK_NS));
   localparam logic [TW-1:0] RAMP_DIV  = TW'(SOFT_START_CYC) /
                                         (START_PER - MIN_PER + 1'b1);

   ////////////////////////////////////////////////////////////////////
   // input synchronisers
   scrc_pkg::scrc_cmp_t s1, c;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s1 <= '0;
         c  <= '0;
      end else begin
         s1 <= cmp_async;
         c  <= s1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   scrc_pkg::scrc_state_t state, next_state;
   logic          fwd_prev, req_pulse, edge_seen, waiting_edge;
   logic [TW-1:0] off_cnt, period_cnt, cur_period, ramp_div_cnt, blank_cnt;
   logic [3:0]    no_answer, unasked;
   logic          ramp_done, gate_en, sr_grounded, strap_done, sr_armed;
   logic          short_at_start, dcm_armed;
   logic [1:0]    strap_wait;

   wire fwd_edge = c.fwd_fall && !fwd_prev && (blank_cnt == '0);

   ////////////////////////////////////////////////////////////////////
   // Timers
   logic ss_done, uv_done, skip_done, dg_done, on_done, valley_done;
   wire  ss_load = (state == scrc_pkg::SCRC_HANDSHAKE) && (next_state != state);

   scrc_timer #(.W(TW)) u_ss (.sys_clk(sys_clk), .reset(reset), .load(ss_load),
      .count(TW'(SOFT_START_CYC)), .run(1'b1), .done(ss_done));
   // undervoltage filter restarts while comparator is low
   scrc_timer #(.W(TW)) u_uv (.sys_clk(sys_clk), .reset(reset), .load(!c.fb_uv),
      .count(TW'(UV_FILTER_CYC)), .run(1'b1), .done(uv_done));
   scrc_timer #(.W(TW)) u_skip (.sys_clk(sys_clk), .reset(reset), .load(req_pulse),
      .count(TW'(SKIP_CYC)), .run(1'b1), .done(skip_done));
   scrc_timer #(.W(TW)) u_dg (.sys_clk(sys_clk), .reset(reset), .load(!c.fb_short),
      .count(TW'(DEGLITCH_CYC)), .run(1'b1), .done(dg_done));
   scrc_timer #(.W(TW)) u_on (.sys_clk(sys_clk), .reset(reset), .load(req_pulse),
      .count(TW'(ON_TIMEOUT_CYC)), .run(1'b1), .done(on_done));
   scrc_timer #(.W(TW)) u_val (.sys_clk(sys_clk), .reset(reset),
      .load(c.dcm_seen), .count(TW'(VALLEY_CYC)), .run(1'b1), .done(valley_done));

   ////////////////////////////////////////////////////////////////////
   // State machine
   wire no_answer_full = (no_answer >= `SCRC_NO_ANSWER_MAX);
   wire unasked_full   = (unasked >= `SCRC_UNASKED_MAX);
   wire handshake_fail = no_answer_full || unasked_full;
   // open gate only counts when drive not strapped off
   wire open_gate = c.gate_small && !sr_grounded && strap_done;
   // short check armed only after soft-start
   wire short_fault = (state == scrc_pkg::SCRC_RUN) && dg_done;
   wire ss_uv_fault = (state == scrc_pkg::SCRC_SOFTSTART) && ss_done && c.fb_uv;
   wire ov_fault = c.fb_ov20 || (c.supply_oc && in_control);

   always_comb begin
      next_state = state;
      case (state)
         scrc_pkg::SCRC_IDLE:
            next_state = scrc_pkg::SCRC_HANDSHAKE;
         scrc_pkg::SCRC_HANDSHAKE:
            if (edge_seen && req_pulse) next_state = scrc_pkg::SCRC_SOFTSTART;
         scrc_pkg::SCRC_SOFTSTART:
            if (ss_uv_fault || open_gate || ov_fault)
               next_state = scrc_pkg::SCRC_FAULT;
            // abort lifts pacing only; the timer still arms the checks
            else if (ss_done)
               next_state = short_at_start ? scrc_pkg::SCRC_FAULT
                                           : scrc_pkg::SCRC_RUN;
         scrc_pkg::SCRC_RUN:
            if (short_fault || uv_done || open_gate || ov_fault)
               next_state = scrc_pkg::SCRC_FAULT;
            else if (handshake_fail) next_state = scrc_pkg::SCRC_HANDSHAKE;
         scrc_pkg::SCRC_FAULT:
            if (skip_done && !fault_latch_option) next_state = scrc_pkg::SCRC_IDLE;
         default:
            next_state = scrc_pkg::SCRC_IDLE;
      endcase
   end

   assign in_control = (state == scrc_pkg::SCRC_SOFTSTART) ||
                       (state == scrc_pkg::SCRC_RUN);
   assign handshake_restart = (state == scrc_pkg::SCRC_RUN) &&
                              (next_state == scrc_pkg::SCRC_HANDSHAKE);
   wire   hs_begin = handshake_restart || (state == scrc_pkg::SCRC_IDLE);

   ////////////////////////////////////////////////////////////////////
   // Request gating
   // Window runs only once discontinuous mode has been seen
   wire valley_gate = c.ring_large || (dcm_armed && !valley_done);
   wire valley_ok   = !valley_gate || c.fwd_fall;
   wire may_request = (state != scrc_pkg::SCRC_FAULT) &&
                      (state != scrc_pkg::SCRC_IDLE) &&
                      (off_cnt == '0) && (period_cnt == '0) &&
                      (!waiting_edge || on_done) && valley_ok &&
                      !c.fb_in_reg;
   assign req_pulse = may_request;
   assign cycle_request = req_pulse;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cur_period   <= START_PER;
         ramp_div_cnt <= '0;
         ramp_done    <= 1'b0;
      end else if (state == scrc_pkg::SCRC_IDLE || state == scrc_pkg::SCRC_HANDSHAKE) begin
         cur_period   <= START_PER;
         ramp_div_cnt <= '0;
         ramp_done    <= 1'b0;
      end else if (ramp_done) begin
         cur_period <= MIN_PER;
      end else if (state != scrc_pkg::SCRC_SOFTSTART || (c.fb_in_reg && qr_programmed)) begin
         // Leaving soft-start or early regulation: full request rate
         cur_period <= MIN_PER;
         ramp_done  <= 1'b1;
      end else if (cur_period > MIN_PER) begin
         ramp_div_cnt <= (ramp_div_cnt >= RAMP_DIV) ? '0 : ramp_div_cnt + 1'b1;
         if (ramp_div_cnt >= RAMP_DIV) cur_period <= cur_period - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fwd_prev     <= 1'b0;
         off_cnt      <= '0;
         period_cnt   <= '0;
         blank_cnt    <= '0;
         waiting_edge <= 1'b0;
         edge_seen    <= 1'b0;
         no_answer    <= '0;
         unasked      <= '0;
         dcm_armed    <= 1'b0;
      end else begin
         fwd_prev   <= c.fwd_fall;
         off_cnt    <= fwd_edge ? MIN_OFF : (off_cnt != '0 ? off_cnt - 1'b1 : '0);
         period_cnt <= req_pulse ? cur_period
                                 : (period_cnt != '0 ? period_cnt - 1'b1 : '0);
         blank_cnt  <= (c.fwd_fall && !fwd_prev) ? BLANK
                       : (blank_cnt != '0 ? blank_cnt - 1'b1 : '0);
         if (req_pulse) waiting_edge <= 1'b1;
         else if (fwd_edge || on_done) waiting_edge <= 1'b0;
         if (c.dcm_seen) dcm_armed <= 1'b1;
         // A fresh handshake needs a fresh answer
         if (hs_begin) edge_seen <= 1'b0;
         else if (fwd_edge) edge_seen <= 1'b1;
         // answer counting, saturating so it cannot wrap
         if (hs_begin || fwd_edge) no_answer <= '0;
         else if (waiting_edge && on_done && !no_answer_full) no_answer <= no_answer + 1'b1;
         if (hs_begin || (fwd_edge && waiting_edge)) unasked <= '0;
         else if (fwd_edge && !unasked_full) unasked <= unasked + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // strap caught after reset release
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sr_grounded    <= 1'b0;
         strap_done     <= 1'b0;
         strap_wait     <= '0;
         short_at_start <= 1'b0;
         state          <= scrc_pkg::SCRC_IDLE;
      end else begin
         state <= next_state;
         // Wait for the synchroniser to fill before taking straps
         if (!strap_done && strap_wait != `SCRC_SYNC_STAGES) begin
            strap_wait <= strap_wait + 1'b1;
         end else if (!strap_done) begin
            sr_grounded    <= c.gate_grounded;
            short_at_start <= c.fb_short;
            strap_done     <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sr_armed <= 1'b0;
         gate_en  <= 1'b0;
      end else begin
         if (req_pulse) sr_armed <= 1'b1;
         else if (fwd_edge) sr_armed <= 1'b0;
         if (req_pulse || c.cs_surge || !in_control || sr_grounded)
            gate_en <= 1'b0;
         else if (fwd_edge && sr_armed)
            gate_en <= 1'b1;
      end
   end
   assign sync_rectifier_gate = gate_en && in_control;
   assign gate_pulldown = !in_control;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) prot <= '0;
      else begin
         prot.bleed_weak   <= c.fb_ov2 && !c.fb_ov10;
         prot.bleed_strong <= c.fb_ov10;
         prot.fault_cmd    <= ov_fault && in_control;
         prot.fault_latch  <= fault_latch_option;
         prot.cc_active    <= c.cs_over;
      end
   end

   ////////////////////////////////////////////////////////////////////
   fault_release_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state == scrc_pkg::SCRC_RUN && uv_done) |=> state == scrc_pkg::SCRC_FAULT)
      else $error("undervoltage did not release control");
   gate_low_a: assert property (@(posedge sys_clk) disable iff (reset)
      !in_control |=> !gate_en)
      else $error("gate driven while not in control");
   gate_req_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      req_pulse |=> !gate_en)
      else $error("gate still on after request");
   surge_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      c.cs_surge |=> !sync_rectifier_gate)
      else $error("gate on during surge");
   strong_bleed_a: assert property (@(posedge sys_clk) disable iff (reset)
      c.fb_ov10 |=> prot.bleed_strong && in_control == $past(in_control))
      else $error("strong bleed missing");
   weak_bleed_a: assert property (@(posedge sys_clk) disable iff (reset)
      (c.fb_ov2 && !c.fb_ov10) |=> prot.bleed_weak)
      else $error("weak bleed missing");
   min_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      fwd_edge |=> !req_pulse [*8])
      else $error("request inside minimum off-time");
   fault_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == scrc_pkg::SCRC_FAULT |-> !cycle_request)
      else $error("request during fault");
   ov_cmd_a: assert property (@(posedge sys_clk) disable iff (reset)
      (c.fb_ov20 && in_control) |=> prot.fault_cmd)
      else $error("overvoltage fault command missing");
   gate_cause_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(gate_en) |-> $past(fwd_edge) && $past(sr_armed))
      else $error("gate without request and edge");
endmodule
`default_nettype wire

//--- test/scrc_primary_model.sv
/*
 Behavioural primary-side switch controller answering cycle requests.
 Assumes one-cycle requests on sys_clk; answers with a forward falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module scrc_primary_model (
   input  wire logic       sys_clk,
   input  wire logic       cycle_request,
   input  wire logic       mute,
   input  wire logic [7:0] delay,
   output logic            fwd_fall
);
   int cnt = 0;
   initial fwd_fall = 1'b0;
   ////////////////////////////////////////////////////////////////
   // answer past blanking
   // Answer lands after the 800 ns blanking; mute models a lost link
   always @(posedge sys_clk) begin
      if (cycle_request && !mute) begin
         cnt <= 250 + int'(delay);
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      fwd_fall <= (cnt > 0) && (cnt <= 4);
   end
endmodule
`default_nettype wire

//--- test/test_secondary_cycle_request_control.sv
/*
 Self-checking bench for scrc_top with a primary-side model.
 Assumes scrc_pkg and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_secondary_cycle_request_control;
   localparam int ON_TO = 1500;
   typedef struct {string name; int which; logic [7:0] exp; int wait_max;} scrc_note_t;
   logic                sys_clk = 1'b0;
   logic                reset = 1'b1;
   scrc_pkg::scrc_cmp_t cmp, cmp_in;
   scrc_pkg::scrc_prot_t prot;
   logic                qr_programmed, fault_latch_option, mute, forward_winding_sense;
   logic [7:0]          delay, exp;
   logic                cycle_request, sync_rectifier_gate, gate_pulldown;
   logic                in_control, handshake_restart;
   logic                pending = 0, edge_seen = 0, prev_req = 0, prev_gate = 0, prev_fwd = 0;
   int                  num_errors = 0, n_compared = 0, age = 0;
   int                  since_edge = 100000, wait_req = 0, surge_age = 0, ring_age = 0;
   int                  lim [5] = '{2600, 400, 5000, 20, 20};
   scrc_note_t          notes [$];

   always #2 sys_clk = ~sys_clk;
   always_comb begin
      cmp_in = cmp;
      cmp_in.fwd_fall = forward_winding_sense;
   end

   scrc_top #(.SOFT_START_CYC(200), .UV_FILTER_CYC(200), .SKIP_CYC(200),
      .DEGLITCH_CYC(2000), .ON_TIMEOUT_CYC(ON_TO), .VALLEY_CYC(5000)) dut_u (
      .sys_clk(sys_clk), .reset(reset), .cmp_async(cmp_in),
      .qr_programmed(qr_programmed), .fault_latch_option(fault_latch_option),
      .cycle_request(cycle_request), .sync_rectifier_gate(sync_rectifier_gate),
      .gate_pulldown(gate_pulldown), .prot(prot), .in_control(in_control),
      .handshake_restart(handshake_restart));

   scrc_primary_model partner_u (.sys_clk(sys_clk), .cycle_request(cycle_request),
      .mute(mute), .delay(delay), .fwd_fall(forward_winding_sense));

   ////////////////////////////////////////////////////////////////
   task automatic compare(input string name, input logic [7:0] e, input logic [7:0] got);
      n_compared++;
      if (got !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, e, got);
      end
   endtask

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic expect_out(input string name, input int which, input logic [7:0] e,
                             input int wait_max);
      notes.push_back('{name, which, e, wait_max});
      while (notes.size() > 0) @(negedge sys_clk);
   endtask

   task automatic start_up;
      reset = 1'b1;
      repeat (3) @(negedge sys_clk);
      reset = 1'b0;
      expect_out("in_control", 1, 8'h01, 40000);
   endtask

   function automatic logic [7:0] pick(input int which);
      case (which)
         0: pick = {3'h0, prot};
         1: pick = {7'h0, in_control};
         2: pick = {7'h0, handshake_restart};
         default: pick = {7'h0, sync_rectifier_gate};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   // Oldest note is settled once its output shows up or its wait runs out
   always @(negedge sys_clk) begin
      if (notes.size() > 0) begin
         if (pick(notes[0].which) === notes[0].exp || age >= notes[0].wait_max) begin
            compare(notes[0].name, notes[0].exp, pick(notes[0].which));
            void'(notes.pop_front());
            age = 0;
         end else begin
            age++;
         end
      end
      if (in_control !== 1'b1)
         compare("gate_released", 8'h01, {7'h0, gate_pulldown & ~sync_rectifier_gate});
      if (prev_req)
         compare("gate_after_request", 8'h00, {7'h0, sync_rectifier_gate});
      if (sync_rectifier_gate && !prev_gate)
         compare("gate_cause", 8'h01, {7'h0, edge_seen});
      if (surge_age > 4)
         compare("gate_in_surge", 8'h00, {7'h0, sync_rectifier_gate});
      if (ring_age > 4)
         compare("valley_gate", 8'h00, {7'h0, cycle_request});
      if (cycle_request === 1'b1)
         compare("request_spacing", 8'h01,
                 {7'h0, since_edge >= 400 && (!pending || wait_req >= ON_TO - 500)});
      surge_age = cmp.cs_surge ? surge_age + 1 : 0;
      ring_age = cmp.ring_large ? ring_age + 1 : 0;
      since_edge = (forward_winding_sense && !prev_fwd) ? 0 : since_edge + 1;
      if (reset) begin
         since_edge = 100000;
         pending = 0;
         edge_seen = 0;
      end else if (cycle_request) begin
         pending = 1;
         edge_seen = 0;
         wait_req = 0;
         delay = 8'($urandom_range(0, 63));
      end else if (forward_winding_sense && !prev_fwd && pending) begin
         pending = 0;
         edge_seen = 1;
      end else begin
         wait_req++;
      end
      prev_req = cycle_request;
      prev_gate = sync_rectifier_gate;
      prev_fwd = forward_winding_sense;
   end

   initial begin
      repeat (90000) @(negedge sys_clk);
      num_errors++;
      end_of_test;
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      cmp = '0;
      qr_programmed = 1'b1;
      fault_latch_option = 1'b0;
      mute = 1'b0;
      delay = 8'h00;
      void'($urandom(27));
      start_up;
      $display("test start_up done");
      cmp.fb_ov2 = 1'b1;
      expect_out("prot", 0, 8'h10, 20);
      cmp.fb_ov2 = 1'b0;
      cmp.fb_ov10 = 1'b1;
      expect_out("prot", 0, 8'h08, 20);
      cmp.fb_ov10 = 1'b0;
      cmp.cs_over = 1'b1;
      expect_out("prot", 0, 8'h01, 20);
      cmp.cs_over = 1'b0;
      expect_out("in_control", 1, 8'h01, 1);
      $display("test bleed done");
      cmp.ring_large = 1'b1;
      repeat (3000) @(negedge sys_clk);
      cmp.ring_large = 1'b0;
      $display("test valley done");
      cmp.cs_surge = 1'b1;
      repeat (3000) @(negedge sys_clk);
      cmp.cs_surge = 1'b0;
      expect_out("gate", 3, 8'h01, 6000);
      $display("test surge done");
      mute = 1'b1;
      expect_out("handshake_restart", 2, 8'h01, 33000);
      mute = 1'b0;
      $display("test lost link done");
      // Each fault ends in the fault state; only the latch option holds it there until reset
      for (int k = 0; k < 5; k++) begin
         cmp = '0;
         start_up;
         fault_latch_option = 1'($urandom_range(0, 1));
         case (k)
            0: cmp.fb_short = 1'b1;
            1: cmp.fb_uv = 1'b1;
            2: cmp.gate_small = 1'b1;
            3: cmp.fb_ov20 = 1'b1;
            default: cmp.supply_oc = 1'b1;
         endcase
         exp = (k < 3) ? 8'h00 : {6'h01, fault_latch_option, 1'b0};
         expect_out((k < 3) ? "in_control" : "prot", (k < 3) ? 1 : 0, exp, lim[k]);
         $display("test fault %0d done", k);
      end
      end_of_test;
   end
endmodule
`default_nettype wire
